// File: hubpdc_defs.svh
/*
 * Offsets, field positions, reset values and sizes for the hub port
 * disable and power configuration slice.
 * Assumes it is included by its bare name from the package and modules.
 */
// Summary of operation
// - Eight-bit self-powered disable mask; bit n set disables port n, ports 1-7.
// - Separate eight-bit bus-powered disable mask with the same per-port encoding.
// - Bit 0 of both disable masks is reserved and always reads zero.
// - With re-mapping off, flagged ports are disabled and cannot be enabled by host.
// - Any port mix may be disabled; reported port count equals enabled ports.
// - Remaining active ports are renumbered contiguously for the host.
// - With internal default configuration and re-mapping off, strap pin pairs 7..1 choose disabled ports.
// - Eight-bit self-powered max power value, in 2 mA units, is stored.
// - Bit 3 of configuration byte 3 selects standard numbering or re-map mode.
`ifndef HUBPDC_DEFS_SVH
`define HUBPDC_DEFS_SVH

// Register offsets on the configuration port
`define HUBPDC_ADDR_CFG3       8'h08
`define HUBPDC_ADDR_DIS_SP     8'h0A
`define HUBPDC_ADDR_DIS_BP     8'h0B
`define HUBPDC_ADDR_MAXPWR_SP  8'h0C

// Field positions
`define HUBPDC_REMAP_BIT       3
`define HUBPDC_NPORTS          7

// Writable bits of the disable masks (bit 0 reserved) and of configuration byte 3
`define HUBPDC_DIS_WMASK       8'hFE
`define HUBPDC_CFG3_WMASK      8'h08

// Reset values
`define HUBPDC_RST_DIS_SP      8'h00
`define HUBPDC_RST_DIS_BP      8'h00
`define HUBPDC_RST_MAXPWR_SP   8'h32
`define HUBPDC_RST_CFG3        8'h00

// Max power unit in mA and the largest legal declared value
`define HUBPDC_MAXPWR_UNIT_MA  2
`define HUBPDC_MAXPWR_LIMIT_MA 100

`endif

// File: hubpdc_pkg.sv
/*
 * Types shared by the hub port disable configuration modules.
 * Assumes hubpdc_defs.svh is on the include path.
 */
`include "hubpdc_defs.svh"

package hubpdc_pkg;
    typedef logic [7:0]  hubpdc_byte_t;
    typedef logic [2:0]  hubpdc_pnum_t;
    typedef logic [23:0] hubpdc_map_t;

    // Where the effective disable mask is taken from
    typedef enum logic [1:0] {
        HUBPDC_SRC_NONE,
        HUBPDC_SRC_SELF,
        HUBPDC_SRC_BUS,
        HUBPDC_SRC_STRAP
    } hubpdc_src_t;
endpackage

// File: hubpdc_remap.sv
/*
 * Port count and contiguous renumbering from a per-port disable mask.
 * Purely combinational; assumes bit 0 of the mask is unused.
 */
`timescale 1ns/1ns
`default_nettype none

module hubpdc_remap
    import hubpdc_pkg::*;
(
    input  wire hubpdc_byte_t i_disable,      // Physical port disable bits
    output var  hubpdc_pnum_t o_count,        // Number of enabled ports
    output var  hubpdc_map_t  o_phys_to_log,  // Logical number per port
    output var  hubpdc_map_t  o_log_to_phys   // Physical port per number
);

    hubpdc_pnum_t prefix [0:7];
    logic  [7:0]  en;

    assign prefix[0] = 3'h0;
    assign en[0]     = 1'b0;
    assign o_phys_to_log[2:0] = 3'h0;

    // Running count of enabled ports gives each its logical number
    genvar p;
    generate
        for (p = 1; p <= 7; p++) begin : g_port
            assign en[p]     = ~i_disable[p];
            assign prefix[p] = prefix[p-1] + {2'h0, en[p]};
            assign o_phys_to_log[3*p +: 3] = en[p] ? prefix[p] : 3'h0;
        end
    endgenerate

    assign o_count = prefix[7];

    // Inverse map: logical number back to its physical port
    always_comb begin
        o_log_to_phys = '0;
        for (int l = 1; l <= 7; l++) begin
            for (int q = 1; q <= 7; q++) begin
                if (en[q] && (prefix[q] == l[2:0])) begin
                    o_log_to_phys[3*l +: 3] = q[2:0];
                end
            end
        end
    end

endmodule // hubpdc_remap

`default_nettype wire

// File: hubpdc_top.sv
/*
 * Hub port disable and self-powered max power configuration slice:
 * register storage on the configuration port, strap capture, mask
 * selection and registered port maps towards the hub core.
 * Assumes a loader (serial EEPROM or SMBus slave) drives the byte port
 * in the I_CLK domain; strap and power-mode pins are asynchronous.
 */
`timescale 1ns/1ns
`default_nettype none
`include "hubpdc_defs.svh"

module hubpdc_top
    import hubpdc_pkg::*;
(
    input  wire  logic          I_CLK,            // 100 MHz system clock
    input  wire  logic          I_SRST,           // Sync reset, active high
    input  wire  logic          I_CE,             // Clock enable
    input  wire  logic [7:0]    I_CFG_ADDR,       // Config byte address
    input  wire  logic          I_CFG_WR,         // Config write strobe
    input  wire  logic [7:0]    I_CFG_WDATA,      // Config write data
    input  wire  logic          I_CFG_RD,         // Config read strobe
    output var   logic [7:0]    O_CFG_RDATA,      // Config read data
    input  wire  logic          I_SELF_POWERED,   // Pin: 1 self, 0 bus
    input  wire  logic          I_DEFAULT_CFG,    // Pin: internal default
    input  wire  logic [7:1]    I_STRAP_PLUS,     // Plus strap per port
    input  wire  logic [7:1]    I_STRAP_MINUS,    // Minus strap per port
    output var   logic [7:0]    O_PORT_ENABLED,   // Enabled physical ports
    output var   logic [2:0]    O_PORT_COUNT,     // Ports shown to host
    output var   logic [23:0]   O_PHYS_TO_LOG,    // Logical no. per port
    output var   logic [23:0]   O_LOG_TO_PHYS,    // Port per logical no.
    output var   logic [7:0]    O_MAX_POWER_SP,   // Max power, 2 mA units
    output var   logic          O_REMAP_ENABLE    // Re-map mode selected
);

    // Stored configuration
    hubpdc_byte_t sp_mask_r;
    hubpdc_byte_t bp_mask_r;
    hubpdc_byte_t maxpwr_r;
    logic         remap_r;
    hubpdc_byte_t rdata_r;

    // Pin synchronisers: {default, self, minus[7:1], plus[7:1]}
    logic [15:0]  pin_meta_r;
    logic [15:0]  pin_sync_r;
    logic         self_s;
    logic         default_s;
    logic [7:1]   plus_s;
    logic [7:1]   minus_s;

    // Selection and mapping
    hubpdc_src_t  src;
    hubpdc_byte_t strap_dis;
    hubpdc_byte_t eff_dis;
    hubpdc_byte_t en_nxt;
    hubpdc_pnum_t count_nxt;
    hubpdc_map_t  p2l_nxt;
    hubpdc_map_t  l2p_nxt;

    logic wr_sp;
    logic wr_bp;
    logic wr_pwr;
    logic wr_cfg3;

    // Reset image of configuration byte 3, so its re-map bit can be picked
    localparam hubpdc_byte_t RST_CFG3 = `HUBPDC_RST_CFG3;

    // Address decode for writes
    always_comb begin
        wr_sp   = 1'b0;
        wr_bp   = 1'b0;
        wr_pwr  = 1'b0;
        wr_cfg3 = 1'b0;
        if (I_CFG_ADDR == `HUBPDC_ADDR_DIS_SP) begin
            wr_sp = I_CFG_WR;
        end else if (I_CFG_ADDR == `HUBPDC_ADDR_DIS_BP) begin
            wr_bp = I_CFG_WR;
        end else if (I_CFG_ADDR == `HUBPDC_ADDR_MAXPWR_SP) begin
            wr_pwr = I_CFG_WR;
        end else if (I_CFG_ADDR == `HUBPDC_ADDR_CFG3) begin
            wr_cfg3 = I_CFG_WR;
        end
    end

    // Self-powered disable mask, reserved bit forced low
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            sp_mask_r <= `HUBPDC_RST_DIS_SP;
        end else if (I_CE && wr_sp) begin
            sp_mask_r <= I_CFG_WDATA & `HUBPDC_DIS_WMASK;
        end
    end

    // Bus-powered disable mask, reserved bit forced low
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            bp_mask_r <= `HUBPDC_RST_DIS_BP;
        end else if (I_CE && wr_bp) begin
            bp_mask_r <= I_CFG_WDATA & `HUBPDC_DIS_WMASK;
        end
    end

    // Self-powered max power, stored as written in 2 mA units
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            maxpwr_r <= `HUBPDC_RST_MAXPWR_SP;
        end else if (I_CE && wr_pwr) begin
            maxpwr_r <= I_CFG_WDATA;
        end
    end

    // Re-map enable bit of configuration byte 3
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            remap_r <= RST_CFG3[`HUBPDC_REMAP_BIT];
        end else if (I_CE && wr_cfg3) begin
            remap_r <= I_CFG_WDATA[`HUBPDC_REMAP_BIT];
        end
    end

    // Registered read data; unmapped addresses read zero
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            rdata_r <= 8'h00;
        end else if (I_CE && I_CFG_RD) begin
            if (I_CFG_ADDR == `HUBPDC_ADDR_DIS_SP) begin
                rdata_r <= sp_mask_r;
            end else if (I_CFG_ADDR == `HUBPDC_ADDR_DIS_BP) begin
                rdata_r <= bp_mask_r;
            end else if (I_CFG_ADDR == `HUBPDC_ADDR_MAXPWR_SP) begin
                rdata_r <= maxpwr_r;
            end else if (I_CFG_ADDR == `HUBPDC_ADDR_CFG3) begin
                rdata_r <= {4'h0, remap_r, 3'h0};
            end else begin
                rdata_r <= 8'h00;
            end
        end
    end

    assign O_CFG_RDATA    = rdata_r;
    assign O_MAX_POWER_SP = maxpwr_r;
    assign O_REMAP_ENABLE = remap_r;

    // Two-stage synchroniser for the asynchronous pins
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            pin_meta_r <= 16'h0000;
            pin_sync_r <= 16'h0000;
        end else if (I_CE) begin
            pin_meta_r <= {I_DEFAULT_CFG, I_SELF_POWERED,
                           I_STRAP_MINUS, I_STRAP_PLUS};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign default_s = pin_sync_r[15];
    assign self_s    = pin_sync_r[14];
    assign minus_s   = pin_sync_r[13:7];
    assign plus_s    = pin_sync_r[6:0];

    // A port is strapped off when both pins of its pair are high
    assign strap_dis = {plus_s & minus_s, 1'b0};

    // Choose which mask disables ports
    always_comb begin
        if (remap_r) begin
            src = HUBPDC_SRC_NONE;
        end else if (default_s) begin
            src = HUBPDC_SRC_STRAP;
        end else if (self_s) begin
            src = HUBPDC_SRC_SELF;
        end else begin
            src = HUBPDC_SRC_BUS;
        end
    end

    always_comb begin
        case (src)
            HUBPDC_SRC_SELF:  eff_dis = sp_mask_r;
            HUBPDC_SRC_BUS:   eff_dis = bp_mask_r;
            HUBPDC_SRC_STRAP: eff_dis = strap_dis;
            default:          eff_dis = 8'h00;
        endcase
    end

    assign en_nxt = ~eff_dis & `HUBPDC_DIS_WMASK;

    hubpdc_remap u_remap (
        .i_disable     (eff_dis),
        .o_count       (count_nxt),
        .o_phys_to_log (p2l_nxt),
        .o_log_to_phys (l2p_nxt)
    );

    // Registered view towards the hub core
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_PORT_ENABLED <= 8'h00;
            O_PORT_COUNT   <= 3'h0;
            O_PHYS_TO_LOG  <= 24'h00_0000;
            O_LOG_TO_PHYS  <= 24'h00_0000;
        end else if (I_CE) begin
            O_PORT_ENABLED <= en_nxt;
            O_PORT_COUNT   <= count_nxt;
            O_PHYS_TO_LOG  <= p2l_nxt;
            O_LOG_TO_PHYS  <= l2p_nxt;
        end
    end

    // Checks on the stored configuration, the mask selection and the published port view
    AST_SP_BIT0_ZERO: assert property (
        @(posedge I_CLK) disable iff (I_SRST)
        sp_mask_r[0] == 1'b0
    ) else $error("self-powered mask bit 0 not zero");

    AST_BP_BIT0_ZERO: assert property (
        @(posedge I_CLK) disable iff (I_SRST)
        bp_mask_r[0] == 1'b0
    ) else $error("bus-powered mask bit 0 not zero");

    AST_SP_WRITE: assert property (
        @(posedge I_CLK) disable iff (I_SRST)
        (I_CE && I_CFG_WR && I_CFG_ADDR == `HUBPDC_ADDR_DIS_SP)
        |=> sp_mask_r == ($past(I_CFG_WDATA) & `HUBPDC_DIS_WMASK)
    ) else $error("self-powered mask write not stored");

    AST_BP_WRITE: assert property (
        @(posedge I_CLK) disable iff (I_SRST)
        (I_CE && I_CFG_WR && I_CFG_ADDR == `HUBPDC_ADDR_DIS_BP)
        |=> bp_mask_r == ($past(I_CFG_WDATA) & `HUBPDC_DIS_WMASK)
    ) else $error("bus-powered mask write not stored");

    AST_MAXPWR_WRITE: assert property (
        @(posedge I_CLK) disable iff (I_SRST)
        (I_CE && I_CFG_WR && I_CFG_ADDR == `HUBPDC_ADDR_MAXPWR_SP)
        |=> O_MAX_POWER_SP == $past(I_CFG_WDATA)
    ) else $error("max power write not stored");

    AST_DISABLED_STAY_OFF: assert property (
        @(posedge I_CLK) disable iff (I_SRST)
        I_CE |=> (O_PORT_ENABLED & $past(eff_dis)) == 8'h00
    ) else $error("disabled port shown as enabled");

    AST_COUNT_MATCHES: assert property (
        @(posedge I_CLK) disable iff (I_SRST)
        I_CE |=> O_PORT_COUNT == $countones(O_PORT_ENABLED)
    ) else $error("port count differs from enabled ports");

    AST_FIRST_IS_ONE: assert property (
        @(posedge I_CLK) disable iff (I_SRST)
        (I_CE && O_PORT_COUNT != 3'h0)
        |-> O_PHYS_TO_LOG[3*O_LOG_TO_PHYS[5:3] +: 3] == 3'h1
    ) else $error("logical port 1 not mapped back");

    AST_REMAP_ALL_ON: assert property (
        @(posedge I_CLK) disable iff (I_SRST)
        (I_CE && remap_r) |=> O_PORT_COUNT == 3'h7
    ) else $error("re-map mode did not expose all ports");

    AST_STRAP_SOURCE: assert property (
        @(posedge I_CLK) disable iff (I_SRST)
        (!remap_r && default_s) |-> eff_dis == strap_dis
    ) else $error("default configuration ignores straps");

    AST_POWER_SOURCE: assert property (
        @(posedge I_CLK) disable iff (I_SRST)
        (!remap_r && !default_s)
        |-> eff_dis == (self_s ? sp_mask_r : bp_mask_r)
    ) else $error("mask does not follow power mode");

endmodule // hubpdc_top

`default_nettype wire

// File: hubpdc_loader.sv
/*
 * Configuration loader model: writes and reads single bytes on the
 * configuration port of the port disable and power slice.
 * Assumes it shares the slice clock and each call starts just after an edge.
 */
`timescale 1ns/1ns
`default_nettype none

module hubpdc_loader (
    input  wire logic       i_clk,   // System clock
    input  wire logic [7:0] i_rdata, // Read data from the slice
    output var  logic [7:0] o_addr,  // Byte address
    output var  logic       o_wr,    // Write strobe
    output var  logic [7:0] o_wdata, // Write data
    output var  logic       o_rd     // Read strobe
);
    // Budget image: 50 units of 2 mA with any zero-current peripheral counted
    localparam logic [7:0] MAX_PWR_IMAGE = 8'h32;

    // Quiet port at time zero
    initial begin
        o_addr  = 8'h00;
        o_wr    = 1'b0;
        o_wdata = 8'h00;
        o_rd    = 1'b0;
    end

    // One byte write; lines flip to the inverse once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        o_addr  = a;
        o_wdata = d;
        o_wr    = 1'b1;
        @(posedge i_clk);
        #1;
        o_wr    = 1'b0;
        o_addr  = ~a;
        o_wdata = ~d;
        // Idle edge so the next call never re-drives a line in this step
        @(posedge i_clk);
        #1;
    endtask

    // One byte read; data is registered at the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        o_addr = a;
        o_rd   = 1'b1;
        @(posedge i_clk);
        #1;
        d      = i_rdata;
        o_rd   = 1'b0;
        o_addr = ~a;
        // Idle edge so the next call never re-drives a line in this step
        @(posedge i_clk);
        #1;
    endtask

    // Loads the default power budget, never above the 100 mA ceiling
    task automatic image();
        wr(8'h0C, MAX_PWR_IMAGE);
    endtask
endmodule // hubpdc_loader

`default_nettype wire

// File: hubpdc_tb.sv
/*
 * Self-checking testbench for the hub port disable and power slice.
 * Assumes the loader model drives the configuration port.
 */
`timescale 1ns/1ns
`default_nettype none

module hubpdc_tb;
    logic        clk      = 1'b0;
    logic        srst     = 1'b1;
    logic        ce       = 1'b1;
    logic        self_pwr = 1'b0;
    logic        dflt     = 1'b0;
    logic [7:1]  sp       = 7'h00;
    logic [7:1]  sm       = 7'h00;
    logic [7:0]  addr;
    logic        wr;
    logic [7:0]  wdata;
    logic        rd;
    logic [7:0]  rdata;
    logic [7:0]  en;
    logic [2:0]  cnt;
    logic [23:0] p2l;
    logic [23:0] l2p;
    logic [7:0]  maxp;
    logic        remap;
    int          mismatches = 0;
    int          n_compared = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    hubpdc_top dut_u (
        .I_CLK(clk), .I_SRST(srst), .I_CE(ce), .I_CFG_ADDR(addr),
        .I_CFG_WR(wr), .I_CFG_WDATA(wdata), .I_CFG_RD(rd),
        .O_CFG_RDATA(rdata), .I_SELF_POWERED(self_pwr),
        .I_DEFAULT_CFG(dflt), .I_STRAP_PLUS(sp), .I_STRAP_MINUS(sm),
        .O_PORT_ENABLED(en), .O_PORT_COUNT(cnt), .O_PHYS_TO_LOG(p2l),
        .O_LOG_TO_PHYS(l2p), .O_MAX_POWER_SP(maxp), .O_REMAP_ENABLE(remap)
    );

    hubpdc_loader loader_u (
        .i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
        .o_wdata(wdata), .o_rd(rd)
    );

    // Compares one value and counts it
    task automatic check(input logic [23:0] s, input logic [23:0] e);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask

    // Reads a byte and compares it
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        loader_u.rd(a, d);
        check(24'(d), 24'(e));
    endtask

    // Works out the port view of a mask and compares enable, count and both maps
    task automatic view(input logic [7:0] m);
        logic [23:0] p2l_e;
        logic [23:0] l2p_e;
        logic [2:0]  l;
        p2l_e = '0;
        l2p_e = '0;
        l = 3'd0;
        for (int n = 1; n < 8; n++) begin
            if (!m[n]) begin
                l = l + 3'd1;
                p2l_e[3*n +: 3] = l;
                l2p_e[3*l +: 3] = n[2:0];
            end
        end
        repeat (3) @(posedge clk);
        #1;
        check(24'(en), 24'({~m[7:1], 1'b0}));
        check(24'(cnt), 24'(l));
        check(p2l, p2l_e);
        check(l2p, l2p_e);
    endtask

    // Prints the counts and the verdict, then ends the run
    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        #1;
        srst = 1'b0;
        rdchk(8'h0A, 8'h00);
        rdchk(8'h0B, 8'h00);
        rdchk(8'h0C, 8'h32);
        rdchk(8'h08, 8'h00);
        view(8'h00);
        loader_u.wr(8'h0A, 8'hFF);
        rdchk(8'h0A, 8'hFE);
        loader_u.wr(8'h0B, 8'h01);
        rdchk(8'h0B, 8'h00);
        loader_u.wr(8'h0D, 8'h5A);
        rdchk(8'h0D, 8'h00);
        loader_u.wr(8'h0A, 8'h14);
        loader_u.wr(8'h0B, 8'h82);
        view(8'h82);
        self_pwr = 1'b1;
        view(8'h14);
        loader_u.wr(8'h0C, 8'h2B);
        rdchk(8'h0C, 8'h2B);
        check(24'(maxp), 24'(8'h2B));
        ce = 1'b0;
        loader_u.wr(8'h0C, 8'h11);
        ce = 1'b1;
        rdchk(8'h0C, 8'h2B);
        sp = 7'b1010101;
        sm = 7'b1110001;
        dflt = 1'b1;
        view({7'b1010001, 1'b0});
        loader_u.wr(8'h08, 8'hFF);
        rdchk(8'h08, 8'h08);
        check(24'(remap), 24'(1'b1));
        view(8'h00);
        loader_u.image();
        rdchk(8'h0C, 8'h32);
        stop_test();
    end

    // Watchdog well beyond the roughly 75 cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        stop_test();
    end
endmodule // hubpdc_tb

`default_nettype wire
